// >>> src/tpm_pkg.sv
// Constants, register map and packet carriers of the traffic policer meter.
// Notes on behaviour
// - One token stands for one packet byte.
// - Simple bucket admits bursts up to its depth.
// - Single-rate colors by committed rate, both depths.
// - Two-rate colors by committed and peak buckets.
// - Traffic under committed rate gets conforming action.
// - Committed depth caps first bucket in all modes.
// - Single-rate second bucket capped at excess depth.
// - Two-rate second bucket refills at peak rate.
// - Two-rate second bucket capped at peak depth.
// - Excess or peak settings only in their mode.
// - Green passes unchanged or gets configured code point.
// - Yellow passes, drops, or gets code point 0-63.
// - Remarked yellow dropped while congestion reported.
// - Yellow action used only in three-color modes.
// - Red dropped or remarked; remarked dropped under congestion.
// - Disabled policer neither meters nor acts.
// - Only member classes are policed.
// - Written code point is six bits wide.
package tpm_pkg;

  // Clock and token timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_SECOND = 1000000000;
  localparam logic [27:0] CYCLES_PER_SECOND = 28'(NS_PER_SECOND / CLK_PERIOD_NS);

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLASS_MASK = 8'h04;
  localparam logic [7:0] REG_COMMITTED_RATE = 8'h08;
  localparam logic [7:0] REG_COMMITTED_BURST_DEPTH = 8'h0C;
  localparam logic [7:0] REG_EXCESS_BURST_DEPTH = 8'h10;
  localparam logic [7:0] REG_PEAK_RATE = 8'h14;
  localparam logic [7:0] REG_PEAK_BURST_DEPTH = 8'h18;
  localparam logic [7:0] REG_ACTION = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_FIRST_TOKENS = 8'h24;
  localparam logic [7:0] REG_SECOND_TOKENS = 8'h28;

  // Field positions and widths.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned RATE_W = 27;
  localparam int unsigned TOKEN_W = 32;
  localparam int unsigned CLASS_W = 4;
  localparam int unsigned NUM_CLASSES = 16;
  localparam int unsigned DSCP_W = 6;
  localparam int unsigned LEN_W = 16;
  localparam int unsigned ACT_GREEN_BIT = 0;
  localparam int unsigned ACT_YELLOW_LSB = 1;
  localparam int unsigned ACT_RED_BIT = 3;
  localparam int unsigned ACT_GREEN_DSCP_LSB = 8;
  localparam int unsigned ACT_YELLOW_DSCP_LSB = 16;
  localparam int unsigned ACT_RED_DSCP_LSB = 24;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
  localparam logic [31:0] ACTION_RESET = 32'h0000_0000;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    TPM_MODE_SIMPLE = 2'b00,
    TPM_MODE_SINGLE_RATE = 2'b01,
    TPM_MODE_TWO_RATE = 2'b10
  } tpm_mode_t;

  typedef enum logic [1:0] {
    TPM_GREEN = 2'b00,
    TPM_YELLOW = 2'b01,
    TPM_RED = 2'b10,
    TPM_UNMETERED = 2'b11
  } tpm_color_t;

  typedef enum logic [1:0] {
    TPM_Y_PASS = 2'b00,
    TPM_Y_DROP = 2'b01,
    TPM_Y_MARK = 2'b10
  } tpm_yellow_act_t;

  // Packet descriptor from the classifier.
  typedef struct packed {
    logic [CLASS_W-1:0] class_tag;
    logic [LEN_W-1:0] length;
    logic [DSCP_W-1:0] dscp;
  } tpm_pkt_in_t;

  // Verdict toward the forwarding path.
  typedef struct packed {
    logic [CLASS_W-1:0] class_tag;
    logic [LEN_W-1:0] length;
    logic [DSCP_W-1:0] dscp;
    tpm_color_t color;
    logic drop;
  } tpm_pkt_out_t;

endpackage : tpm_pkg

// >>> src/tpm_policer.sv
// Ingress traffic policer with three metering modes and an AXI4-Lite register slave.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module tpm_policer (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Packets from the classifier.
  input wire tpm_pkg::tpm_pkt_in_t pkt_in,
  input wire logic pkt_in_valid,
  output logic pkt_in_ready,
  // Verdicts to the forwarding path.
  output tpm_pkg::tpm_pkt_out_t pkt_out,
  output logic pkt_out_valid,
  input wire logic pkt_out_ready,
  // Congestion level from the network path, asynchronous.
  input wire logic congestion
);

  // Configuration registers.
  logic enable_ff;
  tpm_pkg::tpm_mode_t mode_ff;
  logic [tpm_pkg::NUM_CLASSES-1:0] class_mask_ff;
  logic [tpm_pkg::RATE_W-1:0] committed_rate_ff;
  logic [tpm_pkg::TOKEN_W-1:0] committed_burst_depth_ff;
  logic [tpm_pkg::TOKEN_W-1:0] excess_burst_depth_ff;
  logic [tpm_pkg::RATE_W-1:0] peak_rate_ff;
  logic [tpm_pkg::TOKEN_W-1:0] peak_burst_depth_ff;
  logic [31:0] action_ff;

  // Bus slave state.
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic wr_hit;

  // Metering state.
  logic [tpm_pkg::TOKEN_W-1:0] first_tokens_ff;
  logic [tpm_pkg::TOKEN_W-1:0] second_tokens_ff;
  logic [tpm_pkg::RATE_W-1:0] commit_frac_ff;
  logic [tpm_pkg::RATE_W-1:0] peak_frac_ff;
  logic [1:0] commit_credit;
  logic [1:0] peak_credit;
  logic [tpm_pkg::RATE_W-1:0] nxt_commit_frac;
  logic [tpm_pkg::RATE_W-1:0] nxt_peak_frac;
  logic [tpm_pkg::TOKEN_W-1:0] first_refill;
  logic [tpm_pkg::TOKEN_W-1:0] second_refill;
  logic [tpm_pkg::TOKEN_W-1:0] nxt_first_tokens;
  logic [tpm_pkg::TOKEN_W-1:0] nxt_second_tokens;

  // Congestion synchroniser and packet path.
  logic cong_s1_ff;
  logic cong_s2_ff;
  logic cong_s3_ff;
  logic congested_ff;
  tpm_pkg::tpm_pkt_out_t pkt_out_ff;
  tpm_pkg::tpm_pkt_out_t nxt_pkt_out;
  logic pkt_out_valid_ff;
  logic pkt_take;
  logic metered;
  logic [tpm_pkg::TOKEN_W-1:0] pkt_tokens;

  // Adds a credit to a bucket and clamps at its depth.
  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b,
                                          input logic [31:0] cap);
    logic [32:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    sat_add = (sum > {1'b0, cap}) ? cap : sum[31:0];
  endfunction : sat_add

  // Turns a byte rate into per-cycle token credits with an exact fractional remainder.
  function automatic logic [28:0] rate_step(input logic [26:0] frac, input logic [26:0] rate);
    logic [27:0] sum;
    sum = {1'b0, frac} + {1'b0, rate};
    if (sum >= {tpm_pkg::CYCLES_PER_SECOND[26:0], 1'b0}) begin
      rate_step = {2'd2, 27'(sum - {tpm_pkg::CYCLES_PER_SECOND[26:0], 1'b0})};
    end else if (sum >= tpm_pkg::CYCLES_PER_SECOND) begin
      rate_step = {2'd1, 27'(sum - tpm_pkg::CYCLES_PER_SECOND)};
    end else begin
      rate_step = {2'd0, sum[26:0]};
    end
  endfunction : rate_step

  // Write channels are taken independently, in either order or in the same cycle, the response follows both.
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit = (awaddr_ff <= tpm_pkg::REG_ACTION) && (awaddr_ff[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; status and token counters are read-only and answer with an error on write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= tpm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? tpm_pkg::RESP_OKAY : tpm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Configuration store with byte strobes applied to a merged word.
  logic [31:0] cur_word;
  logic [31:0] new_word;
  always_comb begin
    case (awaddr_ff)
      tpm_pkg::REG_CTRL: cur_word = {29'd0, mode_ff, enable_ff};
      tpm_pkg::REG_CLASS_MASK: cur_word = {16'h0000, class_mask_ff};
      tpm_pkg::REG_COMMITTED_RATE: cur_word = {5'd0, committed_rate_ff};
      tpm_pkg::REG_COMMITTED_BURST_DEPTH: cur_word = committed_burst_depth_ff;
      tpm_pkg::REG_EXCESS_BURST_DEPTH: cur_word = excess_burst_depth_ff;
      tpm_pkg::REG_PEAK_RATE: cur_word = {5'd0, peak_rate_ff};
      tpm_pkg::REG_PEAK_BURST_DEPTH: cur_word = peak_burst_depth_ff;
      tpm_pkg::REG_ACTION: cur_word = action_ff;
      default: cur_word = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      new_word[8*i +: 8] = wstrb_ff[i] ? wdata_ff[8*i +: 8] : cur_word[8*i +: 8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_ff <= tpm_pkg::CTRL_RESET[tpm_pkg::CTRL_ENABLE_BIT];
      mode_ff <= tpm_pkg::tpm_mode_t'(tpm_pkg::CTRL_RESET[tpm_pkg::CTRL_MODE_LSB +: 2]);
      class_mask_ff <= tpm_pkg::ZERO_RESET[15:0];
      committed_rate_ff <= tpm_pkg::ZERO_RESET[tpm_pkg::RATE_W-1:0];
      committed_burst_depth_ff <= tpm_pkg::ZERO_RESET;
      excess_burst_depth_ff <= tpm_pkg::ZERO_RESET;
      peak_rate_ff <= tpm_pkg::ZERO_RESET[tpm_pkg::RATE_W-1:0];
      peak_burst_depth_ff <= tpm_pkg::ZERO_RESET;
      action_ff <= tpm_pkg::ACTION_RESET;
    end else if (wr_fire && wr_hit) begin
      case (awaddr_ff)
        tpm_pkg::REG_CTRL: begin
          enable_ff <= new_word[tpm_pkg::CTRL_ENABLE_BIT];
          mode_ff <= tpm_pkg::tpm_mode_t'(new_word[tpm_pkg::CTRL_MODE_LSB +: 2]);
        end
        tpm_pkg::REG_CLASS_MASK: class_mask_ff <= new_word[15:0];
        tpm_pkg::REG_COMMITTED_RATE: committed_rate_ff <= new_word[tpm_pkg::RATE_W-1:0];
        tpm_pkg::REG_COMMITTED_BURST_DEPTH: committed_burst_depth_ff <= new_word;
        tpm_pkg::REG_EXCESS_BURST_DEPTH: excess_burst_depth_ff <= new_word;
        tpm_pkg::REG_PEAK_RATE: peak_rate_ff <= new_word[tpm_pkg::RATE_W-1:0];
        tpm_pkg::REG_PEAK_BURST_DEPTH: peak_burst_depth_ff <= new_word;
        tpm_pkg::REG_ACTION: action_ff <= new_word;
        default: action_ff <= action_ff;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= tpm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= tpm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        tpm_pkg::REG_CTRL: rdata_ff <= {29'd0, mode_ff, enable_ff};
        tpm_pkg::REG_CLASS_MASK: rdata_ff <= {16'h0000, class_mask_ff};
        tpm_pkg::REG_COMMITTED_RATE: rdata_ff <= {5'd0, committed_rate_ff};
        tpm_pkg::REG_COMMITTED_BURST_DEPTH: rdata_ff <= committed_burst_depth_ff;
        tpm_pkg::REG_EXCESS_BURST_DEPTH: rdata_ff <= excess_burst_depth_ff;
        tpm_pkg::REG_PEAK_RATE: rdata_ff <= {5'd0, peak_rate_ff};
        tpm_pkg::REG_PEAK_BURST_DEPTH: rdata_ff <= peak_burst_depth_ff;
        tpm_pkg::REG_ACTION: rdata_ff <= action_ff;
        tpm_pkg::REG_STATUS: rdata_ff <= {31'd0, congested_ff};
        tpm_pkg::REG_FIRST_TOKENS: rdata_ff <= first_tokens_ff;
        tpm_pkg::REG_SECOND_TOKENS: rdata_ff <= second_tokens_ff;
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= tpm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Congestion is a pin level; it only changes once the second and third stages agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cong_s1_ff <= 1'b0;
      cong_s2_ff <= 1'b0;
      cong_s3_ff <= 1'b0;
      congested_ff <= 1'b0;
    end else begin
      cong_s1_ff <= congestion;
      cong_s2_ff <= cong_s1_ff;
      cong_s3_ff <= cong_s2_ff;
      if (cong_s2_ff == cong_s3_ff) begin
        congested_ff <= cong_s3_ff;
      end
    end
  end

  // Per-cycle token credits; the second bucket only earns peak credits in two-rate mode.
  always_comb begin
    {commit_credit, nxt_commit_frac} = rate_step(commit_frac_ff, committed_rate_ff);
    {peak_credit, nxt_peak_frac} = rate_step(peak_frac_ff, peak_rate_ff);
  end

  // Refill: the first bucket is always capped by the committed depth.
  logic [32:0] first_sum;
  logic [31:0] spill;
  always_comb begin
    first_sum = {1'b0, first_tokens_ff} + {31'd0, commit_credit};
    first_refill = sat_add(first_tokens_ff, {30'd0, commit_credit},
                           committed_burst_depth_ff);
    spill = (first_sum > {1'b0, committed_burst_depth_ff}) ?
            32'(first_sum - {1'b0, committed_burst_depth_ff}) : 32'h0000_0000;
    case (mode_ff)
      tpm_pkg::TPM_MODE_SINGLE_RATE:
        second_refill = sat_add(second_tokens_ff, spill, excess_burst_depth_ff);
      tpm_pkg::TPM_MODE_TWO_RATE:
        second_refill = sat_add(second_tokens_ff, {30'd0, peak_credit},
                                peak_burst_depth_ff);
      default: second_refill = 32'h0000_0000;
    endcase
  end

  // Coloring, action choice and token consumption for an accepted packet.
  assign pkt_out_valid = pkt_out_valid_ff;
  assign pkt_out = pkt_out_ff;
  assign pkt_in_ready = !pkt_out_valid_ff || pkt_out_ready;
  assign pkt_take = pkt_in_valid && pkt_in_ready;
  assign metered = enable_ff && class_mask_ff[pkt_in.class_tag];
  assign pkt_tokens = {16'h0000, pkt_in.length};

  always_comb begin
    nxt_pkt_out.class_tag = pkt_in.class_tag;
    nxt_pkt_out.length = pkt_in.length;
    nxt_pkt_out.dscp = pkt_in.dscp;
    nxt_pkt_out.color = tpm_pkg::TPM_UNMETERED;
    nxt_pkt_out.drop = 1'b0;
    nxt_first_tokens = first_refill;
    nxt_second_tokens = second_refill;
    if (metered) begin
      case (mode_ff)
        tpm_pkg::TPM_MODE_SINGLE_RATE: begin
          if (first_refill >= pkt_tokens) begin
            nxt_pkt_out.color = tpm_pkg::TPM_GREEN;
            nxt_first_tokens = first_refill - pkt_tokens;
          end else if (second_refill >= pkt_tokens) begin
            nxt_pkt_out.color = tpm_pkg::TPM_YELLOW;
            nxt_second_tokens = second_refill - pkt_tokens;
          end else begin
            nxt_pkt_out.color = tpm_pkg::TPM_RED;
          end
        end
        tpm_pkg::TPM_MODE_TWO_RATE: begin
          if (second_refill < pkt_tokens) begin
            nxt_pkt_out.color = tpm_pkg::TPM_RED;
          end else if (first_refill < pkt_tokens) begin
            nxt_pkt_out.color = tpm_pkg::TPM_YELLOW;
            nxt_second_tokens = second_refill - pkt_tokens;
          end else begin
            nxt_pkt_out.color = tpm_pkg::TPM_GREEN;
            nxt_first_tokens = first_refill - pkt_tokens;
            nxt_second_tokens = second_refill - pkt_tokens;
          end
        end
        default: begin
          // Simple bucket: the depth bounds any burst, so no yellow can appear.
          if (first_refill >= pkt_tokens) begin
            nxt_pkt_out.color = tpm_pkg::TPM_GREEN;
            nxt_first_tokens = first_refill - pkt_tokens;
          end else begin
            nxt_pkt_out.color = tpm_pkg::TPM_RED;
          end
        end
      endcase
      case (nxt_pkt_out.color)
        tpm_pkg::TPM_GREEN: begin
          if (action_ff[tpm_pkg::ACT_GREEN_BIT]) begin
            nxt_pkt_out.dscp = action_ff[tpm_pkg::ACT_GREEN_DSCP_LSB +: tpm_pkg::DSCP_W];
          end
        end
        tpm_pkg::TPM_YELLOW: begin
          // Only the three-color modes reach here.
          case (tpm_pkg::tpm_yellow_act_t'(action_ff[tpm_pkg::ACT_YELLOW_LSB +: 2]))
            tpm_pkg::TPM_Y_DROP: nxt_pkt_out.drop = 1'b1;
            tpm_pkg::TPM_Y_MARK: begin
              nxt_pkt_out.dscp = action_ff[tpm_pkg::ACT_YELLOW_DSCP_LSB +: tpm_pkg::DSCP_W];
              nxt_pkt_out.drop = congested_ff;
            end
            default: nxt_pkt_out.drop = 1'b0;
          endcase
        end
        default: begin
          // Red: remarking keeps it only while the path is not congested.
          if (action_ff[tpm_pkg::ACT_RED_BIT]) begin
            nxt_pkt_out.dscp = action_ff[tpm_pkg::ACT_RED_DSCP_LSB +: tpm_pkg::DSCP_W];
            nxt_pkt_out.drop = congested_ff;
          end else begin
            nxt_pkt_out.drop = 1'b1;
          end
        end
      endcase
    end
  end

  // Buckets refill every cycle and pay for a metered packet when it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_tokens_ff <= tpm_pkg::ZERO_RESET;
      second_tokens_ff <= tpm_pkg::ZERO_RESET;
      commit_frac_ff <= tpm_pkg::ZERO_RESET[tpm_pkg::RATE_W-1:0];
      peak_frac_ff <= tpm_pkg::ZERO_RESET[tpm_pkg::RATE_W-1:0];
    end else begin
      commit_frac_ff <= nxt_commit_frac;
      peak_frac_ff <= nxt_peak_frac;
      first_tokens_ff <= pkt_take ? nxt_first_tokens : first_refill;
      second_tokens_ff <= pkt_take ? nxt_second_tokens : second_refill;
    end
  end

  // One-deep verdict register; it stalls the classifier while the forwarding path is busy.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_out_valid_ff <= 1'b0;
      pkt_out_ff <= '0;
    end else if (pkt_in_ready) begin
      pkt_out_valid_ff <= pkt_in_valid;
      if (pkt_in_valid) begin
        pkt_out_ff <= nxt_pkt_out;
      end
    end
  end

endmodule : tpm_policer

// >>> tb/tpm_policer_sva.sv
// Protocol and verdict assertions for the traffic policer meter.
`timescale 1ns/100ps
module tpm_policer_sva (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Packet stream.
  input wire tpm_pkg::tpm_pkt_in_t pkt_in,
  input wire logic pkt_in_valid,
  input wire logic pkt_in_ready,
  input wire tpm_pkg::tpm_pkt_out_t pkt_out,
  input wire logic pkt_out_valid,
  input wire logic pkt_out_ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Bus answers come on time and stand until they are taken.
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved");

  // A verdict follows each packet and waits for the forwarding path.
  a_verdict_next: assert property (pkt_in_valid && pkt_in_ready
    |=> pkt_out_valid && pkt_out.length == $past(pkt_in.length)) else $error("verdict missing");
  a_verdict_hold: assert property (pkt_out_valid && !pkt_out_ready |=> pkt_out_valid && $stable(pkt_out))
    else $error("verdict moved");
  a_in_stall: assert property (pkt_out_valid && !pkt_out_ready |-> !pkt_in_ready)
    else $error("packet taken while stalled");
  a_foreign_pass: assert property ((pkt_in_valid && pkt_in_ready) ##1
    (pkt_out.color == tpm_pkg::TPM_UNMETERED) |-> pkt_out.dscp == $past(pkt_in.dscp) && !pkt_out.drop)
    else $error("unmetered packet altered");
  a_green_kept: assert property (pkt_out_valid && pkt_out.color == tpm_pkg::TPM_GREEN |-> !pkt_out.drop)
    else $error("green packet dropped");
endmodule : tpm_policer_sva

// >>> tb/tpm_fwd_model.sv
// Downstream forwarding queue model that can stall the verdict stream.
`timescale 1ns/100ps
module tpm_fwd_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Stall request from the bench.
  input wire logic stall,
  // Verdict handshake.
  input wire logic pkt_out_valid,
  output logic pkt_out_ready
);
  logic [1:0] cnt_ff;

  // A stalled queue is ready on one valid cycle in four, so verdicts must wait in place.
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_ff <= 2'h0;
    else if (pkt_out_valid) cnt_ff <= cnt_ff + 2'h1;
  end
  assign pkt_out_ready = !stall || (cnt_ff == 2'h3);
endmodule : tpm_fwd_model

// >>> tb/tpm_policer_bench.sv
// Self-checking bench for the traffic policer meter.
`timescale 1ns/100ps
module tpm_policer_bench;
  localparam logic [1:0] C_G = tpm_pkg::TPM_GREEN;
  localparam logic [1:0] C_Y = tpm_pkg::TPM_YELLOW;
  localparam logic [1:0] C_R = tpm_pkg::TPM_RED;
  localparam logic [1:0] C_U = tpm_pkg::TPM_UNMETERED;
  logic aclk, aresetn, stall, congestion;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  tpm_pkg::tpm_pkt_in_t pkt_in;
  tpm_pkg::tpm_pkt_out_t pkt_out;
  logic pkt_in_valid, pkt_in_ready, pkt_out_valid, pkt_out_ready;
  int n_fail, n_tests;

  tpm_policer dut (.*);
  tpm_fwd_model u_fwd (.*);

  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // A wait that used up its bound ends the run, since later steps would only cascade.
  task tmo(input int i);
    if (i >= 60) begin
      n_fail++;
      $display("[FAIL] %0t wait ran out", $time);
      end_sim();
    end
  endtask : tmo

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) break;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    tmo(i);
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    int i;
    logic ta;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) break;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    tmo(i);
    chk(32'(s_axi_rresp), 32'(er));
    chk(s_axi_rdata, ed);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axr

  // Sends one descriptor with code point 0x2A and compares the verdict's length, color, code point and drop.
  task send(input logic [3:0] cl, input logic [15:0] len, input logic [8:0] ex);
    int i;
    @(posedge aclk);
    pkt_in <= {cl, len, 6'h2A};
    pkt_in_valid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(negedge aclk);
      if (pkt_in_ready) break;
    end
    tmo(i);
    @(posedge aclk);
    pkt_in_valid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(negedge aclk);
      if (pkt_out_valid && pkt_out_ready) break;
    end
    tmo(i);
    chk({7'h0, pkt_out.length, pkt_out.color, pkt_out.dscp, pkt_out.drop}, {7'h0, len, ex});
  endtask : send

  // Tokens fill at about 1.34 bytes a cycle at the highest rate, so 300 cycles fill any depth here.
  initial begin
    n_fail = 0;
    n_tests = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {pkt_in_valid, stall, congestion, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    pkt_in = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(tpm_pkg::REG_CTRL, tpm_pkg::RESP_OKAY, 32'h0);
    axr(8'h30, tpm_pkg::RESP_SLVERR, 32'h0);
    axw(tpm_pkg::REG_STATUS, 32'h1, tpm_pkg::RESP_SLVERR);
    axw(tpm_pkg::REG_CLASS_MASK, 32'h4, tpm_pkg::RESP_OKAY);
    axw(tpm_pkg::REG_COMMITTED_RATE, 32'h07FF_FFFF, tpm_pkg::RESP_OKAY);
    axw(tpm_pkg::REG_COMMITTED_BURST_DEPTH, 32'h64, tpm_pkg::RESP_OKAY);
    axw(tpm_pkg::REG_EXCESS_BURST_DEPTH, 32'h96, tpm_pkg::RESP_OKAY);
    axw(tpm_pkg::REG_PEAK_RATE, 32'h07FF_FFFF, tpm_pkg::RESP_OKAY);
    axw(tpm_pkg::REG_PEAK_BURST_DEPTH, 32'hC8, tpm_pkg::RESP_OKAY);
    axw(tpm_pkg::REG_ACTION, 32'h2109_050D, tpm_pkg::RESP_OKAY);
    axw(tpm_pkg::REG_CTRL, 32'h1, tpm_pkg::RESP_OKAY);
    repeat (300) @(posedge aclk);
    axr(tpm_pkg::REG_FIRST_TOKENS, tpm_pkg::RESP_OKAY, 32'h64);
    axr(tpm_pkg::REG_SECOND_TOKENS, tpm_pkg::RESP_OKAY, 32'h0);
    send(4'h2, 16'h64, {C_G, 6'h05, 1'b0});
    send(4'h2, 16'h64, {C_R, 6'h21, 1'b0});
    send(4'h3, 16'h64, {C_U, 6'h2A, 1'b0});
    $display("test simple bucket done");
    axw(tpm_pkg::REG_CTRL, 32'h3, tpm_pkg::RESP_OKAY);
    repeat (300) @(posedge aclk);
    axr(tpm_pkg::REG_SECOND_TOKENS, tpm_pkg::RESP_OKAY, 32'h96);
    send(4'h2, 16'h64, {C_G, 6'h05, 1'b0});
    send(4'h2, 16'h28, {C_Y, 6'h09, 1'b0});
    stall <= 1'b1;
    send(4'h2, 16'h80, {C_R, 6'h21, 1'b0});
    @(posedge aclk);
    stall <= 1'b0;
    congestion <= 1'b1;
    repeat (300) @(posedge aclk);
    send(4'h2, 16'h64, {C_G, 6'h05, 1'b0});
    send(4'h2, 16'h28, {C_Y, 6'h09, 1'b1});
    send(4'h2, 16'h80, {C_R, 6'h21, 1'b1});
    @(posedge aclk);
    congestion <= 1'b0;
    $display("test single rate done");
    axw(tpm_pkg::REG_CTRL, 32'h5, tpm_pkg::RESP_OKAY);
    repeat (300) @(posedge aclk);
    axr(tpm_pkg::REG_SECOND_TOKENS, tpm_pkg::RESP_OKAY, 32'hC8);
    send(4'h2, 16'h96, {C_Y, 6'h09, 1'b0});
    send(4'h2, 16'h64, {C_R, 6'h21, 1'b0});
    send(4'h2, 16'h28, {C_G, 6'h05, 1'b0});
    axw(tpm_pkg::REG_ACTION, 32'h0000_0002, tpm_pkg::RESP_OKAY);
    repeat (300) @(posedge aclk);
    send(4'h2, 16'h96, {C_Y, 6'h2A, 1'b1});
    send(4'h2, 16'h64, {C_R, 6'h2A, 1'b1});
    send(4'h2, 16'h28, {C_G, 6'h2A, 1'b0});
    $display("test two rate done");
    @(posedge aclk);
    s_axi_wstrb <= 4'h2;
    axw(tpm_pkg::REG_CLASS_MASK, 32'h0000_0100, tpm_pkg::RESP_OKAY);
    axr(tpm_pkg::REG_CLASS_MASK, tpm_pkg::RESP_OKAY, 32'h0000_0104);
    s_axi_wstrb <= 4'hF;
    axw(tpm_pkg::REG_CTRL, 32'h0, tpm_pkg::RESP_OKAY);
    send(4'h2, 16'h0A, {C_U, 6'h2A, 1'b0});
    $display("test disabled done");
    end_sim();
  end
endmodule : tpm_policer_bench

bind tpm_policer tpm_policer_sva u_sva (.*);
